// >>> rsrc_pkg.sv
package rsrc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CAUSE  = 8'h04;
    localparam logic [7:0] OFF_RECSRC = 8'h08;
    localparam logic [7:0] OFF_OSC    = 8'h0c;
    localparam logic [7:0] OFF_WDT    = 8'h10;
    localparam logic [7:0] OFF_PWR    = 8'h14;
    localparam logic [7:0] OFF_MODE   = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_DBG_RST = 0;
    localparam int CTRL_PIN_IND = 1;
    localparam int CAUSE_POR    = 7;
    localparam int CAUSE_STOP   = 6;
    localparam int CAUSE_WDT    = 5;
    localparam int CAUSE_PIN    = 4;
    localparam int CAUSE_BOD    = 3;
    localparam int OSC_XTAL_EN  = 0;
    localparam int OSC_XTAL_SEL = 1;
    localparam int OSC_WDOSC_EN = 2;
    localparam int WDT_EN       = 0;
    localparam int PWR_AMP_EN   = 0;

    // ------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [7:0]  RECSRC_RST      = 8'h00;
    localparam logic [2:0]  OSC_RST         = 3'h0;
    localparam logic        WDT_EN_RST      = 1'b0;
    localparam int          PIN_LOW_SAMPLES = 4;
    localparam int          REC_XTAL_OFF    = 66;
    localparam int          REC_XTAL_ON     = 5000;
    localparam int          RST_DELAY       = 66;
    localparam logic [15:0] VEC_ADDR_HI     = 16'h0002;
    localparam logic [15:0] VEC_ADDR_LO     = 16'h0003;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_RESET   = 6'h01,
        ST_FETCH   = 6'h02,
        ST_RUN     = 6'h04,
        ST_HALT    = 6'h08,
        ST_STOP    = 6'h10,
        ST_RECOVER = 6'h20
    } rsrc_state_t;

    typedef struct packed {
        logic pri_osc_run;
        logic ipo_run;
        logic sys_clk_run;
        logic cpu_run;
        logic wdt_osc_run;
        logic wdt_run;
        logic amp_run;
        logic bod_run;
        logic xtal_pins_en;
        logic pa_low_gpio;
        logic clk_sel_xtal;
    } rsrc_power_t;

    typedef struct packed {
        logic        pm_rd;
        logic [15:0] pm_addr;
        logic        pc_load;
        logic [15:0] pc_value;
    } rsrc_fetch_t;

endpackage : rsrc_pkg

// >>> rsrc_pin_filter.sv
`timescale 1ns/1ps

module rsrc_pin_filter #(
    parameter int SAMPLES = rsrc_pkg::PIN_LOW_SAMPLES
) (
    input  wire logic pclk,     // System clock
    input  wire logic presetn,  // Async reset, active low
    input  wire logic clk_en,   // Freezes state while low
    input  wire logic pin_in,   // Raw reset pin level
    output logic      pin_low   // Pin seen low long enough
);

    if (SAMPLES < 1 || SAMPLES > 15) begin : g_chk
        $error("rsrc_pin_filter: SAMPLES out of range");
    end

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic [3:0] cnt;
        logic       low;
    } rsrc_filt_t;

    rsrc_filt_t r_reg;
    rsrc_filt_t r_next;

    // Two-stage synchroniser then a run-length count of low samples;
    // short glitches never reach the sequencer
    always_comb begin
        r_next = r_reg;
        r_next.s1 = pin_in;
        r_next.s2 = r_reg.s1;
        if (r_reg.s2) begin
            r_next.cnt = 4'h0;
            r_next.low = 1'b0;
        end else if (r_reg.cnt == 4'(SAMPLES - 1)) begin
            r_next.low = 1'b1;
        end else begin
            r_next.cnt = r_reg.cnt + 4'h1;
        end
    end

    // Idle level is high so a reset release reads as pin released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '{s1: 1'b1, s2: 1'b1, cnt: 4'h0, low: 1'b0};
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    assign pin_low = r_reg.low;

endmodule : rsrc_pin_filter

// >>> rsrc_ctrl.sv
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps

module rsrc_ctrl #(
    parameter int REC_ON_CYC  = rsrc_pkg::REC_XTAL_ON,   // Recovery with crystal on
    parameter int REC_OFF_CYC = rsrc_pkg::REC_XTAL_OFF,  // Recovery with crystal off
    parameter int RST_CYC     = rsrc_pkg::RST_DELAY      // Internal reset delay
) (
    input  wire logic                  pclk,         // System clock, 25 MHz
    input  wire logic                  presetn,      // Async reset, active low
    input  wire logic                  clk_en,       // Clock enable
    input  wire logic                  psel,         // APB select
    input  wire logic                  penable,      // APB enable
    input  wire logic                  pwrite,       // APB direction
    input  wire logic [7:0]            paddr,        // APB byte address
    input  wire logic [31:0]           pwdata,       // APB write data
    output logic                       pready,       // APB ready
    output logic [31:0]                prdata,       // APB read data
    output logic                       pslverr,      // APB error
    input  wire logic                  rst_pin_in,   // Reset pin level
    output logic                       rst_pin_out,  // Reset pin drive value
    output logic                       rst_pin_oe,   // Reset pin output enable
    input  wire logic                  por_event,    // Power-on event pulse
    input  wire logic                  bod_event,    // Brownout event pulse
    input  wire logic                  wdt_event,    // Watchdog reset pulse
    input  wire logic                  bod_stop_opt, // Brownout-in-STOP option
    input  wire logic                  stop_exec,    // CPU stop instruction
    input  wire logic                  halt_exec,    // CPU halt instruction
    input  wire logic                  wake_irq,     // Interrupt ends HALT
    input  wire logic [7:0]            port_pins,    // Port pin levels
    input  wire logic                  ipo_tick,     // One oscillator cycle
    input  wire logic [7:0]            pm_data,      // Program memory byte
    output logic                       sys_rst_n,    // Chip reset, active low
    output logic                       dbg_rst_n,    // Debug unit reset
    output logic                       cpu_rst_n,    // CPU reset, active low
    output rsrc_pkg::rsrc_power_t      power,        // Power controls
    output rsrc_pkg::rsrc_fetch_t      fetch         // Vector fetch
);

    if (REC_ON_CYC < 1 || REC_ON_CYC > 8191 || REC_OFF_CYC < 1 || REC_OFF_CYC > 8191
        || RST_CYC < 1 || RST_CYC > 8191) begin : g_chk
        $error("rsrc_ctrl: count parameter out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Block state apart from the pin filter in one record, registered by a single process
    typedef struct packed {
        rsrc_pkg::rsrc_state_t st;
        logic [12:0]           cnt;
        logic                  drive;
        logic                  pin_echo;  // Pin still reads back our own pull
        logic                  dbg_keep;
        logic                  fetch_lo;
        logic [7:0]            vec_hi;
        logic                  dbg_req;
        logic                  pin_ind;
        logic [7:0]            rec_src;
        logic [2:0]            osc;
        logic                  wdt_en;
        logic                  amp_en;
        logic [7:0]            cause;
        logic [7:0]            pins_q;
        logic [31:0]           rdata;
        logic                  err;
        rsrc_pkg::rsrc_fetch_t fch;
    } rsrc_regs_t;

    rsrc_regs_t r_reg;
    rsrc_regs_t r_next;

    logic pin_low;
    logic pin_trig;
    logic int_evt;
    logic wr_acc;
    logic rd_acc;
    logic setup;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Address decode for the error answer; the read mux decodes on its own
    function automatic logic rsrc_hit(input logic [7:0] a);
        rsrc_hit = (a == rsrc_pkg::OFF_CTRL) || (a == rsrc_pkg::OFF_CAUSE)
                || (a == rsrc_pkg::OFF_RECSRC) || (a == rsrc_pkg::OFF_OSC)
                || (a == rsrc_pkg::OFF_WDT) || (a == rsrc_pkg::OFF_PWR)
                || (a == rsrc_pkg::OFF_MODE);
    endfunction : rsrc_hit

    function automatic logic [31:0] rsrc_rd(input logic [7:0] a, input rsrc_regs_t r);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            rsrc_pkg::OFF_CTRL:   d[1:0] = {r.pin_ind, r.dbg_req};
            rsrc_pkg::OFF_CAUSE:  d[7:0] = r.cause;
            rsrc_pkg::OFF_RECSRC: d[7:0] = r.rec_src;
            rsrc_pkg::OFF_OSC:    d[2:0] = r.osc;
            rsrc_pkg::OFF_WDT:    d[0]   = r.wdt_en;
            rsrc_pkg::OFF_PWR:    d[0]   = r.amp_en;
            rsrc_pkg::OFF_MODE:   d[5:0] = r.st;
            default:              d      = 32'h0000_0000;
        endcase
        rsrc_rd = d;
    endfunction : rsrc_rd

    // Recovery length picked from the crystal enable when STOP ends
    function automatic logic [12:0] rsrc_rec_len(input logic xtal);
        rsrc_rec_len = xtal ? 13'(REC_ON_CYC - 1) : 13'(REC_OFF_CYC - 1);
    endfunction : rsrc_rec_len

    // ------------------------------------------------------------
    // Reset pin filter
    // ------------------------------------------------------------
    // Debounced pin: a run of four low samples trips the sequencer
    rsrc_pin_filter #(
        .SAMPLES (rsrc_pkg::PIN_LOW_SAMPLES)
    ) u_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .pin_in  (rst_pin_in),
        .pin_low (pin_low)
    );

    // ------------------------------------------------------------
    // Event terms
    // ------------------------------------------------------------
    // Our own indicator drive would read back as a pin reset, so it masks the trigger
    assign pin_trig = pin_low && !r_reg.pin_ind && !r_reg.drive && !r_reg.pin_echo;
    assign int_evt  = por_event || bod_event || wdt_event || r_reg.dbg_req;
    assign setup    = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign rd_acc   = psel && penable && !pwrite;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.fch.pc_load = 1'b0;
        r_next.fch.pm_rd = 1'b0;

        // The filter keeps reporting our own pull for a few cycles after it
        // ends; hold the mask until the filtered pin has gone high again
        r_next.pin_echo = r_reg.drive || r_reg.pin_ind
                       || (r_reg.pin_echo && pin_low);

        // Read data is captured in the setup phase, one wait-free access follows
        if (setup) begin
            r_next.rdata = rsrc_rd(paddr, r_reg);
            r_next.err = !rsrc_hit(paddr);
        end

        // Register writes
        if (wr_acc) begin
            unique case (paddr)
                rsrc_pkg::OFF_CTRL: begin
                    r_next.dbg_req = pwdata[rsrc_pkg::CTRL_DBG_RST];
                    r_next.pin_ind = pwdata[rsrc_pkg::CTRL_PIN_IND];
                end
                rsrc_pkg::OFF_RECSRC: r_next.rec_src = pwdata[7:0];
                rsrc_pkg::OFF_OSC:    r_next.osc = pwdata[2:0];
                rsrc_pkg::OFF_WDT:    r_next.wdt_en = pwdata[rsrc_pkg::WDT_EN];
                rsrc_pkg::OFF_PWR:    r_next.amp_en = pwdata[rsrc_pkg::PWR_AMP_EN];
                default: ;
            endcase
        end

        // Cause flags clear on read; sets below win over the clear
        if (rd_acc && paddr == rsrc_pkg::OFF_CAUSE) begin
            r_next.cause = r_reg.cause & ~r_reg.rdata[7:0];
        end
        if (por_event || r_reg.dbg_req) begin
            r_next.cause[rsrc_pkg::CAUSE_POR] = 1'b1;
        end
        if (bod_event) begin
            r_next.cause[rsrc_pkg::CAUSE_BOD] = 1'b1;
        end
        if (wdt_event) begin
            r_next.cause[rsrc_pkg::CAUSE_WDT] = 1'b1;
        end

        // Sequencer
        unique case (r_reg.st)
            rsrc_pkg::ST_RESET: begin
                r_next.dbg_req = 1'b0;
                if (r_reg.cnt != 13'h0000) begin
                    r_next.cnt = r_reg.cnt - 13'h0001;
                end else begin
                    r_next.drive = 1'b0;
                    if (!pin_low || r_reg.drive) begin
                        r_next.st = rsrc_pkg::ST_FETCH;
                        r_next.dbg_keep = 1'b0;
                        r_next.fetch_lo = 1'b0;
                        r_next.fch.pm_rd = 1'b1;
                        r_next.fch.pm_addr = rsrc_pkg::VEC_ADDR_HI;
                    end
                end
            end
            rsrc_pkg::ST_FETCH: begin
                // Memory answers one cycle after the read strobe
                if (!r_reg.fch.pm_rd && !r_reg.fetch_lo) begin
                    r_next.vec_hi = pm_data;
                    r_next.fetch_lo = 1'b1;
                    r_next.fch.pm_rd = 1'b1;
                    r_next.fch.pm_addr = rsrc_pkg::VEC_ADDR_LO;
                end else if (!r_reg.fch.pm_rd) begin
                    r_next.fch.pc_value = {r_reg.vec_hi, pm_data};
                    r_next.fch.pc_load = 1'b1;
                    r_next.st = rsrc_pkg::ST_RUN;
                end
            end
            rsrc_pkg::ST_RUN: begin
                if (stop_exec) begin
                    r_next.st = rsrc_pkg::ST_STOP;
                    r_next.pins_q = port_pins;
                end else if (halt_exec) begin
                    r_next.st = rsrc_pkg::ST_HALT;
                end
            end
            rsrc_pkg::ST_HALT: begin
                if (wake_irq) begin
                    r_next.st = rsrc_pkg::ST_RUN;
                end
            end
            rsrc_pkg::ST_STOP: begin
                r_next.pins_q = port_pins;
                if (|((port_pins ^ r_reg.pins_q) & r_reg.rec_src)) begin
                    r_next.st = rsrc_pkg::ST_RECOVER;
                    r_next.cnt = rsrc_rec_len(r_reg.osc[rsrc_pkg::OSC_XTAL_EN]);
                    r_next.cause[rsrc_pkg::CAUSE_STOP] = 1'b1;
                    // Only these two registers are reset on recovery
                    r_next.osc = rsrc_pkg::OSC_RST;
                    r_next.wdt_en = rsrc_pkg::WDT_EN_RST;
                end
            end
            rsrc_pkg::ST_RECOVER: begin
                if (ipo_tick) begin
                    if (r_reg.cnt == 13'h0000) begin
                        r_next.st = rsrc_pkg::ST_FETCH;
                        r_next.fetch_lo = 1'b0;
                        r_next.fch.pm_rd = 1'b1;
                        r_next.fch.pm_addr = rsrc_pkg::VEC_ADDR_HI;
                    end else begin
                        r_next.cnt = r_reg.cnt - 13'h0001;
                    end
                end
            end
        endcase

        // Resets pre-empt every state; internal sources also drive the pin
        if (int_evt) begin
            r_next.st = rsrc_pkg::ST_RESET;
            r_next.cnt = 13'(RST_CYC - 1);
            r_next.drive = 1'b1;
            r_next.dbg_keep = r_reg.dbg_req && !por_event && !bod_event && !wdt_event;
            r_next.rec_src = rsrc_pkg::RECSRC_RST;
            r_next.osc = rsrc_pkg::OSC_RST;
            r_next.wdt_en = rsrc_pkg::WDT_EN_RST;
            r_next.amp_en = 1'b0;
            r_next.pin_ind = 1'b0;
            // The request is used up by the reset that it starts
            r_next.dbg_req = 1'b0;
        end else if (pin_trig && r_reg.st != rsrc_pkg::ST_RESET) begin
            r_next.st = rsrc_pkg::ST_RESET;
            r_next.cnt = 13'h0000;
            r_next.cause[rsrc_pkg::CAUSE_PIN] = 1'b1;
            r_next.rec_src = rsrc_pkg::RECSRC_RST;
            r_next.osc = rsrc_pkg::OSC_RST;
            r_next.wdt_en = rsrc_pkg::WDT_EN_RST;
            r_next.amp_en = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Runs on an always-on clock; the gated system clock is an output only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '{st: rsrc_pkg::ST_RESET, cause: 8'h80, default: '0};
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // No wait states: every access phase completes in one cycle
    assign pready      = 1'b1;
    assign prdata      = r_reg.rdata;
    assign pslverr     = psel && penable && r_reg.err;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe  = r_reg.drive || r_reg.pin_ind;
    assign sys_rst_n   = (r_reg.st != rsrc_pkg::ST_RESET);
    assign dbg_rst_n   = sys_rst_n || r_reg.dbg_keep;
    assign cpu_rst_n   = sys_rst_n && (r_reg.st != rsrc_pkg::ST_RECOVER);
    assign fetch       = r_reg.fch;

    // Power gating per mode
    always_comb begin
        logic stop;
        logic halt;
        stop = (r_reg.st == rsrc_pkg::ST_STOP);
        halt = (r_reg.st == rsrc_pkg::ST_HALT);
        power.pri_osc_run  = !stop && r_reg.osc[rsrc_pkg::OSC_XTAL_EN];
        power.ipo_run      = !stop;
        power.sys_clk_run  = !stop;
        power.cpu_run      = !stop && !halt && cpu_rst_n;
        power.wdt_osc_run  = r_reg.osc[rsrc_pkg::OSC_WDOSC_EN];
        power.wdt_run      = r_reg.wdt_en;
        power.amp_run      = r_reg.amp_en;
        power.bod_run      = !stop || bod_stop_opt;
        power.xtal_pins_en = !stop && r_reg.osc[rsrc_pkg::OSC_XTAL_EN];
        power.pa_low_gpio  = stop || !r_reg.osc[rsrc_pkg::OSC_XTAL_EN];
        power.clk_sel_xtal = r_reg.osc[rsrc_pkg::OSC_XTAL_SEL];
    end

endmodule : rsrc_ctrl

// >>> rsrc_checker.sv
`timescale 1ns/1ps
module rsrc_checker #(
    parameter int REC_ON_CYC  = 5000, // Recovery, crystal on
    parameter int REC_OFF_CYC = 66    // Recovery, crystal off
) (
    input wire logic            pclk,         // Clock
    input wire logic            presetn,      // Reset
    input wire logic            rst_pin_in,   // Pin level
    input wire logic            rst_pin_oe,   // Pin pull
    input wire logic            por_event,    // Power-on
    input wire logic            bod_event,    // Brownout
    input wire logic            wdt_event,    // Watchdog
    input wire logic            bod_stop_opt, // Option
    input wire logic            stop_exec,    // Stop
    input wire logic            ipo_tick,     // Osc tick
    input wire logic            sys_rst_n,    // Chip reset
    input wire logic            cpu_rst_n,    // CPU reset
    input rsrc_pkg::rsrc_power_t power,       // Power
    input rsrc_pkg::rsrc_fetch_t fetch        // Fetch
);
    logic [15:0] tick_cnt;
    logic        in_stop;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Only STOP gates the clock outside reset and recovery
    assign in_stop = sys_rst_n && cpu_rst_n && !power.sys_clk_run;
    // Ticks seen while recovery holds the CPU
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tick_cnt <= 16'h0000;
        else if (sys_rst_n && !cpu_rst_n) tick_cnt <= tick_cnt + {15'h0000, ipo_tick};
        else tick_cnt <= 16'h0000;
    end
    sequence s_hi; fetch.pm_rd && fetch.pm_addr == rsrc_pkg::VEC_ADDR_HI; endsequence
    sequence s_lo; fetch.pm_rd && fetch.pm_addr == rsrc_pkg::VEC_ADDR_LO; endsequence
    property p_four; (!rst_pin_in && !rst_pin_oe)[*4] |-> ##[1:6] !sys_rst_n; endproperty
    a_four: assert property (p_four) else $error("pin pulse missed");
    property p_hold; (!rst_pin_in && !rst_pin_oe && !sys_rst_n)[*3] |=> !sys_rst_n; endproperty
    a_hold: assert property (p_hold) else $error("reset left early");
    property p_evt; por_event || bod_event || wdt_event |-> ##[1:2] (rst_pin_oe && !sys_rst_n)[*4];
    endproperty
    a_evt: assert property (p_evt) else $error("pin not pulled");
    property p_stop; stop_exec && power.cpu_run && cpu_rst_n |=> in_stop; endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_spwr; in_stop |-> !(power.cpu_run || power.ipo_run || power.pri_osc_run
        || power.xtal_pins_en); endproperty
    a_spwr: assert property (p_spwr) else $error("stop power");
    property p_bod; in_stop |-> power.bod_run == bod_stop_opt; endproperty
    a_bod: assert property (p_bod) else $error("brownout in stop");
    property p_rec; sys_rst_n && $past(sys_rst_n) && $rose(cpu_rst_n) |-> tick_cnt inside
        {[REC_OFF_CYC-2:REC_OFF_CYC+2], [REC_ON_CYC-2:REC_ON_CYC+2]}; endproperty
    a_rec: assert property (p_rec) else $error("recovery length");
    property p_vec; $rose(cpu_rst_n) |-> s_hi ##2 s_lo ##[1:2] fetch.pc_load; endproperty
    a_vec: assert property (p_vec) else $error("vector fetch");
endmodule : rsrc_checker

bind rsrc_ctrl rsrc_checker #(.REC_ON_CYC(REC_ON_CYC), .REC_OFF_CYC(REC_OFF_CYC)) chk_u (
    .pclk(pclk), .presetn(presetn), .rst_pin_in(rst_pin_in), .rst_pin_oe(rst_pin_oe),
    .por_event(por_event), .bod_event(bod_event), .wdt_event(wdt_event),
    .bod_stop_opt(bod_stop_opt), .stop_exec(stop_exec), .ipo_tick(ipo_tick),
    .sys_rst_n(sys_rst_n), .cpu_rst_n(cpu_rst_n), .power(power), .fetch(fetch));

// >>> rsrc_pm_model.sv
`timescale 1ns/1ps
module rsrc_pm_model #(
    parameter logic [15:0] VEC = 16'h1234 // Vector in memory
) (
    input wire logic             pclk,    // Clock
    input rsrc_pkg::rsrc_fetch_t fetch,   // Read request
    output logic [7:0]           pm_data  // Memory byte
);
    // Byte follows a read by one cycle; idle bus toggles so late sampling shows
    always @(posedge pclk) begin
        if (fetch.pm_rd !== 1'b1) pm_data <= ~pm_data;
        else if (fetch.pm_addr == rsrc_pkg::VEC_ADDR_HI) pm_data <= VEC[15:8];
        else if (fetch.pm_addr == rsrc_pkg::VEC_ADDR_LO) pm_data <= VEC[7:0];
        else pm_data <= 8'h00;
    end
    initial pm_data = 8'h5a;
endmodule : rsrc_pm_model

// >>> tb_reset_and_stop_recovery_control.sv
`timescale 1ns/1ps
module tb_reset_and_stop_recovery_control;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, err, pin_out, pin_oe, sys_n, dbg_n, cpu_n;
    logic        ext_low = 1'b0, bod_opt = 1'b0, dbg_lo = 1'b0;
    logic [7:0]  paddr = 8'h00, pins = 8'h00, pm_data;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [5:0]  ev = 6'h00; // por bod wdt stop halt wake
    logic [31:0] cm [3] = '{32'h80, 32'h08, 32'h20};
    rsrc_pkg::rsrc_power_t power;
    rsrc_pkg::rsrc_fetch_t fetch;
    int          error_cnt = 0, n_compared = 0, cyc = 0;
    wire         pin = ext_low ? 1'b0 : (pin_oe ? pin_out : 1'b1); // Board pull-up
    rsrc_ctrl #(.REC_ON_CYC(20), .RST_CYC(8)) dut_u (.pclk(pclk), .presetn(presetn),
        .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rst_pin_in(pin), .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .por_event(ev[0]),
        .bod_event(ev[1]), .wdt_event(ev[2]), .bod_stop_opt(bod_opt), .stop_exec(ev[3]),
        .halt_exec(ev[4]), .wake_irq(ev[5]), .port_pins(pins), .ipo_tick(1'b1),
        .pm_data(pm_data), .sys_rst_n(sys_n), .dbg_rst_n(dbg_n), .cpu_rst_n(cpu_n),
        .power(power), .fetch(fetch));
    rsrc_pm_model pm_u (.pclk(pclk), .fetch(fetch), .pm_data(pm_data));
    initial forever #20 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Setup then access; release only after pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r & m, e);
    endtask : rdm
    task automatic wait_mode(input logic [31:0] e);
        r = 32'hffff_ffff; // Force at least one poll
        for (int k = 0; k < 300 && r !== e; k++) apb(1'b0, rsrc_pkg::OFF_MODE, 32'h0);
        chk(r, e);
    endtask : wait_mode
    task automatic pulse(input int b);
        @(posedge pclk);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev[b] <= 1'b0;
    endtask : pulse
    task automatic final_report;
        $display("errors %0d, comparisons %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // Timeout, debug-reset watch and loaded vector
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (dbg_n === 1'b0) dbg_lo <= 1'b1;
        else if (psel && pwrite && pwdata[0]) dbg_lo <= 1'b0;
        if (fetch.pc_load === 1'b1) chk({16'h0, fetch.pc_value}, 32'h1234);
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdm(rsrc_pkg::OFF_CAUSE, 32'hff, 32'h80);
        wait_mode(32'h04);
        rdm(8'h1c, 32'hffffffff, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Crystal off then on: both recovery lengths
        for (int i = 0; i < 2; i++) begin
            pins <= 8'h00;
            bod_opt <= i[0];
            apb(1'b1, rsrc_pkg::OFF_RECSRC, 32'h1);
            apb(1'b1, rsrc_pkg::OFF_OSC, 32'(i));
            apb(1'b1, rsrc_pkg::OFF_WDT, 32'h1);
            apb(1'b1, rsrc_pkg::OFF_PWR, 32'h1);
            pulse(3);
            rdm(rsrc_pkg::OFF_MODE, 32'hff, 32'h10);
            chk({28'h0, power.wdt_run, power.amp_run, power.wdt_osc_run,
                power.pa_low_gpio}, 32'hd);
            pins <= 8'h02;
            rdm(rsrc_pkg::OFF_MODE, 32'hff, 32'h10);
            pins <= 8'h03;
            wait_mode(32'h04);
            rdm(rsrc_pkg::OFF_OSC, 32'h7, 32'h0);
            rdm(rsrc_pkg::OFF_WDT, 32'h1, 32'h0);
            rdm(rsrc_pkg::OFF_PWR, 32'h1, 32'h1);
            rdm(rsrc_pkg::OFF_RECSRC, 32'hff, 32'h1);
            rdm(rsrc_pkg::OFF_CAUSE, 32'h40, 32'h40);
        end
        pulse(4);
        rdm(rsrc_pkg::OFF_MODE, 32'hff, 32'h08);
        pulse(5);
        rdm(rsrc_pkg::OFF_MODE, 32'hff, 32'h04);
        apb(1'b1, rsrc_pkg::OFF_CTRL, 32'h2);
        rdm(rsrc_pkg::OFF_CTRL, 32'h3, 32'h2);
        chk({31'h0, pin_oe}, 32'h1);
        apb(1'b1, rsrc_pkg::OFF_CTRL, 32'h0);
        repeat (4) @(posedge pclk); // Let the released pin settle high
        // Shortest pulse that must reset, then a long hold
        ext_low <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_low <= 1'b0;
        repeat (8) @(posedge pclk);
        wait_mode(32'h04);
        rdm(rsrc_pkg::OFF_CAUSE, 32'h10, 32'h10);
        ext_low <= 1'b1;
        repeat (40) @(posedge pclk);
        rdm(rsrc_pkg::OFF_MODE, 32'hff, 32'h01);
        ext_low <= 1'b0;
        wait_mode(32'h04);
        for (int b = 0; b < 3; b++) begin
            pulse(b);
            wait_mode(32'h04);
            rdm(rsrc_pkg::OFF_CAUSE, cm[b], cm[b]);
        end
        rdm(rsrc_pkg::OFF_CAUSE, 32'h20, 32'h0);
        apb(1'b1, rsrc_pkg::OFF_CTRL, 32'h1);
        wait_mode(32'h04);
        rdm(rsrc_pkg::OFF_CTRL, 32'h1, 32'h0);
        rdm(rsrc_pkg::OFF_CAUSE, 32'h80, 32'h80);
        chk({31'h0, dbg_lo}, 32'h0);
        final_report();
    end
endmodule : tb_reset_and_stop_recovery_control
